/* rtl/tcr_pkg.sv */
package tcr_pkg;

  // register addresses on the plain register port
  localparam logic [7:0] TCR_ADDR_MASK_LO = 8'he0;
  localparam logic [7:0] TCR_ADDR_CAPCTL = 8'he1;
  localparam logic [7:0] TCR_ADDR_BCTL = 8'he2;
  localparam logic [7:0] TCR_ADDR_MAIN = 8'he8;
  localparam logic [7:0] TCR_ADDR_REFILL_HI = 8'he9;
  localparam logic [7:0] TCR_ADDR_REFILL_LO = 8'hea;
  localparam logic [7:0] TCR_ADDR_CAP_HI = 8'heb;
  localparam logic [7:0] TCR_ADDR_CAP_LO = 8'hec;
  localparam logic [7:0] TCR_ADDR_MATCH_HI = 8'hed;
  localparam logic [7:0] TCR_ADDR_MATCH_LO = 8'hee;
  localparam logic [7:0] TCR_ADDR_MASK_HI = 8'hef;

  // timer_main_control bit positions
  localparam int unsigned TCR_MAIN_DIV_HI = 7;
  localparam int unsigned TCR_MAIN_DIV_LO = 6;
  localparam int unsigned TCR_MAIN_REFILL = 5;
  localparam int unsigned TCR_MAIN_RUN = 4;
  localparam int unsigned TCR_MAIN_WRAP_IE = 3;
  localparam int unsigned TCR_MAIN_WRAP_FLAG = 2;
  localparam int unsigned TCR_MAIN_WRAP_STYLE = 1;

  // capture_input_control bit positions
  localparam int unsigned TCR_CAP_ERR_A = 6;
  localparam int unsigned TCR_CAP_ERR_B = 5;
  localparam int unsigned TCR_CAP_IE_A = 4;
  localparam int unsigned TCR_CAP_FLAG_A = 3;
  localparam int unsigned TCR_CAP_EDGE_A = 2;
  localparam int unsigned TCR_CAP_SRC_HI = 1;
  localparam int unsigned TCR_CAP_SRC_LO = 0;

  // input_b_control bit positions
  localparam int unsigned TCR_B_EDGE_B = 7;
  localparam int unsigned TCR_B_IE_B = 6;
  localparam int unsigned TCR_B_FLAG_B = 5;
  localparam int unsigned TCR_B_MATCH_IE = 4;
  localparam int unsigned TCR_B_MATCH_FLAG = 3;
  localparam int unsigned TCR_B_NULL_IE = 2;
  localparam int unsigned TCR_B_NULL_FLAG = 1;

  // restart sources
  localparam logic [1:0] TCR_SRC_SOFT = 2'h0;
  localparam logic [1:0] TCR_SRC_A = 2'h1;
  localparam logic [1:0] TCR_SRC_B = 2'h2;
  localparam logic [1:0] TCR_SRC_NONE = 2'h3;

  // divider selections and their ratios
  localparam logic [1:0] TCR_DIV_OFF = 2'h0;
  localparam logic [1:0] TCR_DIV_SEL1 = 2'h1;
  localparam logic [1:0] TCR_DIV_SEL4 = 2'h2;
  localparam logic [4:0] TCR_RATIO_1 = 5'h01;
  localparam logic [4:0] TCR_RATIO_4 = 5'h04;
  localparam logic [4:0] TCR_RATIO_16 = 5'h10;

  // counter values and reset values
  localparam logic [15:0] TCR_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TCR_CNT_TOP = 16'hffff;
  localparam logic [7:0] TCR_BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [1:0] divider_select;
    logic refill_enable;
    logic run_clear_control;
    logic wrap_irq_enable;
    logic wrap_output_style;
  } tcr_main_s;

  typedef struct packed {
    logic input_a_irq_enable;
    logic input_a_edge_select;
    logic [1:0] restart_source;
  } tcr_capctl_s;

  typedef struct packed {
    logic input_b_edge_select;
    logic input_b_irq_enable;
    logic match_irq_enable;
    logic masked_null_irq_enable;
  } tcr_bctl_s;

endpackage : tcr_pkg

/* rtl/tcr_top.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module tcr_top
  import tcr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_input_a_pin,
  input wire logic i_input_b_pin,
  output logic o_irq,
  output logic o_wrap_output_pin
);

  // active edge of a pin, per its edge select
  function automatic logic tcr_edge(input logic cur, input logic prev,
                                    input logic rise);
    tcr_edge = rise ? (cur && !prev) : (!cur && prev);
  endfunction : tcr_edge
  // masked equality used by match and null compares
  function automatic logic tcr_masked_eq(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] m);
    tcr_masked_eq = ((a & m) == (b & m));
  endfunction : tcr_masked_eq
  // clear-only flag: hardware set wins over a software clear
  function automatic logic tcr_flag_next(input logic cur, input logic set,
                                         input logic wr, input logic wbit);
    tcr_flag_next = set || (cur && !(wr && !wbit));
  endfunction : tcr_flag_next
  // divide ratio for the divider select field
  function automatic logic [4:0] tcr_ratio(input logic [1:0] sel);
    case (sel)
      TCR_DIV_SEL1: tcr_ratio = TCR_RATIO_1;
      TCR_DIV_SEL4: tcr_ratio = TCR_RATIO_4;
      default: tcr_ratio = TCR_RATIO_16;
    endcase
  endfunction : tcr_ratio

  tcr_main_s main_q;
  tcr_capctl_s capctl_q;
  tcr_bctl_s bctl_q;
  logic flag_a_q, err_a_q, flag_b_q, err_b_q;
  logic wrap_flag_q, match_flag_q, null_flag_q;
  logic [15:0] cnt_q, refill_q, cap_q, match_q, mask_q;
  logic [7:0] hi_latch_q, rdata_q, rd_mux;
  logic [3:0] psc_q;
  logic a_prev_q, b_prev_q, run_prev_q, started_q, wrap_pin_q;
  logic wr_main, wr_capctl, wr_bctl, wr_refill_lo, wr_match_lo, wr_mask_lo;
  logic wr_hi, run, refill_en, tick, counting, wrap_evt;
  logic ev_a, ev_b, set_flag_a, set_err_a, set_flag_b, set_err_b;
  logic cap_a, cap_b, load_a, load_b, load_sw, load;
  logic [1:0] src;

  // write decode
  assign wr_main = i_wr && (i_addr == TCR_ADDR_MAIN);
  assign wr_capctl = i_wr && (i_addr == TCR_ADDR_CAPCTL);
  assign wr_bctl = i_wr && (i_addr == TCR_ADDR_BCTL);
  assign wr_refill_lo = i_wr && (i_addr == TCR_ADDR_REFILL_LO);
  assign wr_match_lo = i_wr && (i_addr == TCR_ADDR_MATCH_LO);
  assign wr_mask_lo = i_wr && (i_addr == TCR_ADDR_MASK_LO);
  assign wr_hi = i_wr && ((i_addr == TCR_ADDR_REFILL_HI) ||
                          (i_addr == TCR_ADDR_MATCH_HI) ||
                          (i_addr == TCR_ADDR_MASK_HI));
  assign run = main_q.run_clear_control;
  assign refill_en = main_q.refill_enable;
  assign src = capctl_q.restart_source;

  // divider: one-cycle tick at the selected ratio, none when off
  assign tick = (main_q.divider_select != TCR_DIV_OFF) &&
                ({1'b0, psc_q} == 5'(tcr_ratio(main_q.divider_select)
                                     - TCR_RATIO_1));

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      psc_q <= '0;
    end else if (tick || (main_q.divider_select == TCR_DIV_OFF)) begin
      psc_q <= '0;
    end else begin
      psc_q <= psc_q + 4'h1;
    end
  end

  // edges only seen while running; error flag mutes the input except for the B restart trigger
  assign ev_a = run && !err_a_q &&
                tcr_edge(i_input_a_pin, a_prev_q,
                         capctl_q.input_a_edge_select);
  assign ev_b = run && !err_b_q &&
                tcr_edge(i_input_b_pin, b_prev_q,
                         bctl_q.input_b_edge_select);
  assign set_flag_a = ev_a && !flag_a_q;
  assign set_err_a = ev_a && flag_a_q;
  assign set_flag_b = ev_b && !flag_b_q;
  assign set_err_b = ev_b && flag_b_q;

  // capture paths: B always to capture reg, A only without refill
  assign cap_b = set_flag_b;
  assign cap_a = set_flag_a && !refill_en;

  // restart triggers per source select
  assign load_a = ev_a && refill_en && (src == TCR_SRC_A);
  assign load_b = run && refill_en && (src == TCR_SRC_B) &&
                  tcr_edge(i_input_b_pin, b_prev_q,
                           bctl_q.input_b_edge_select);
  assign load_sw = run && !run_prev_q && refill_en &&
                   (src == TCR_SRC_SOFT);
  assign load = load_a || load_b || load_sw;

  // counter waits at zero for its first trigger in reload modes other than TCR_SRC_NONE
  assign counting = run && (started_q || !refill_en ||
                            (src == TCR_SRC_NONE));
  assign wrap_evt = counting && tick && !load && (cnt_q == TCR_CNT_ZERO);

  // pin history and run history
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      a_prev_q <= i_input_a_pin;
      b_prev_q <= i_input_b_pin;
      run_prev_q <= run;
    end
  end

  // started marker for triggered restart modes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      started_q <= 1'b0;
    end else if (!run) begin
      started_q <= 1'b0;
    end else if (load) begin
      started_q <= 1'b1;
    end
  end

  // down counter
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= TCR_CNT_ZERO;
    end else if (!run) begin
      cnt_q <= TCR_CNT_ZERO;
    end else if (load) begin
      cnt_q <= refill_q;
    end else if (wrap_evt) begin
      cnt_q <= refill_en ? refill_q : TCR_CNT_TOP;
    end else if (counting && tick) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // control registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      main_q <= '0;
      capctl_q <= '0;
      bctl_q <= '0;
    end else begin
      if (wr_main) begin
        main_q.divider_select <=
          i_wdata[TCR_MAIN_DIV_HI:TCR_MAIN_DIV_LO];
        main_q.refill_enable <= i_wdata[TCR_MAIN_REFILL];
        main_q.run_clear_control <= i_wdata[TCR_MAIN_RUN];
        main_q.wrap_irq_enable <= i_wdata[TCR_MAIN_WRAP_IE];
        main_q.wrap_output_style <= i_wdata[TCR_MAIN_WRAP_STYLE];
      end
      if (wr_capctl) begin
        capctl_q.input_a_irq_enable <= i_wdata[TCR_CAP_IE_A];
        capctl_q.input_a_edge_select <= i_wdata[TCR_CAP_EDGE_A];
        capctl_q.restart_source <=
          i_wdata[TCR_CAP_SRC_HI:TCR_CAP_SRC_LO];
      end
      if (wr_bctl) begin
        bctl_q.input_b_edge_select <= i_wdata[TCR_B_EDGE_B];
        bctl_q.input_b_irq_enable <= i_wdata[TCR_B_IE_B];
        bctl_q.match_irq_enable <= i_wdata[TCR_B_MATCH_IE];
        bctl_q.masked_null_irq_enable <= i_wdata[TCR_B_NULL_IE];
      end
    end
  end

  // event and error flags: hardware sets, software writes 0 to clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flag_a_q <= 1'b0;
      err_a_q <= 1'b0;
      flag_b_q <= 1'b0;
      err_b_q <= 1'b0;
      wrap_flag_q <= 1'b0;
      match_flag_q <= 1'b0;
      null_flag_q <= 1'b0;
    end else begin
      flag_a_q <= tcr_flag_next(flag_a_q, set_flag_a, wr_capctl,
                                i_wdata[TCR_CAP_FLAG_A]);
      err_a_q <= tcr_flag_next(err_a_q, set_err_a, wr_capctl,
                               i_wdata[TCR_CAP_ERR_A]);
      flag_b_q <= tcr_flag_next(flag_b_q, set_flag_b, wr_bctl,
                                i_wdata[TCR_B_FLAG_B]);
      err_b_q <= tcr_flag_next(err_b_q, set_err_b, wr_capctl,
                               i_wdata[TCR_CAP_ERR_B]);
      wrap_flag_q <= tcr_flag_next(wrap_flag_q, wrap_evt, wr_main,
                                   i_wdata[TCR_MAIN_WRAP_FLAG]);
      match_flag_q <= tcr_flag_next(match_flag_q,
                        run && tcr_masked_eq(cnt_q, match_q, mask_q),
                        wr_bctl, i_wdata[TCR_B_MATCH_FLAG]);
      null_flag_q <= tcr_flag_next(null_flag_q,
                       run && tcr_masked_eq(cnt_q, TCR_CNT_ZERO, mask_q),
                       wr_bctl, i_wdata[TCR_B_NULL_FLAG]);
    end
  end

  // 16-bit registers: high byte latched, loaded with the low byte
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hi_latch_q <= TCR_BYTE_ZERO;
      match_q <= TCR_CNT_ZERO;
      mask_q <= TCR_CNT_ZERO;
    end else begin
      if (wr_hi) begin
        hi_latch_q <= i_wdata;
      end
      if (wr_match_lo) begin
        match_q <= {hi_latch_q, i_wdata};
      end
      if (wr_mask_lo) begin
        mask_q <= {hi_latch_q, i_wdata};
      end
    end
  end

  // refill register: written only with refill on, else capture target
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      refill_q <= TCR_CNT_ZERO;
    end else if (cap_a) begin
      refill_q <= cnt_q;
    end else if (wr_refill_lo && refill_en) begin
      refill_q <= {hi_latch_q, i_wdata};
    end
  end

  // capture register takes the count before any same-cycle reload
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cap_q <= TCR_CNT_ZERO;
    end else if (cap_b) begin
      cap_q <= cnt_q;
    end
  end

  // wrap pin: set-and-hold or toggle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wrap_pin_q <= 1'b0;
    end else if (wrap_evt) begin
      wrap_pin_q <= main_q.wrap_output_style ? !wrap_pin_q : 1'b1;
    end else if (!main_q.wrap_output_style && !wrap_flag_q) begin
      wrap_pin_q <= 1'b0;
    end
  end

  // read mux; reserved bits read 0
  always_comb begin
    rd_mux = TCR_BYTE_ZERO;
    case (i_addr)
      TCR_ADDR_MAIN: begin
        rd_mux[TCR_MAIN_DIV_HI:TCR_MAIN_DIV_LO] = main_q.divider_select;
        rd_mux[TCR_MAIN_REFILL] = main_q.refill_enable;
        rd_mux[TCR_MAIN_RUN] = main_q.run_clear_control;
        rd_mux[TCR_MAIN_WRAP_IE] = main_q.wrap_irq_enable;
        rd_mux[TCR_MAIN_WRAP_FLAG] = wrap_flag_q;
        rd_mux[TCR_MAIN_WRAP_STYLE] = main_q.wrap_output_style;
      end
      TCR_ADDR_CAPCTL: begin
        rd_mux[TCR_CAP_ERR_A] = err_a_q;
        rd_mux[TCR_CAP_ERR_B] = err_b_q;
        rd_mux[TCR_CAP_IE_A] = capctl_q.input_a_irq_enable;
        rd_mux[TCR_CAP_FLAG_A] = flag_a_q;
        rd_mux[TCR_CAP_EDGE_A] = capctl_q.input_a_edge_select;
        rd_mux[TCR_CAP_SRC_HI:TCR_CAP_SRC_LO] = src;
      end
      TCR_ADDR_BCTL: begin
        rd_mux[TCR_B_EDGE_B] = bctl_q.input_b_edge_select;
        rd_mux[TCR_B_IE_B] = bctl_q.input_b_irq_enable;
        rd_mux[TCR_B_FLAG_B] = flag_b_q;
        rd_mux[TCR_B_MATCH_IE] = bctl_q.match_irq_enable;
        rd_mux[TCR_B_MATCH_FLAG] = match_flag_q;
        rd_mux[TCR_B_NULL_IE] = bctl_q.masked_null_irq_enable;
        rd_mux[TCR_B_NULL_FLAG] = null_flag_q;
      end
      TCR_ADDR_REFILL_HI: rd_mux = refill_q[15:8];
      TCR_ADDR_REFILL_LO: rd_mux = refill_q[7:0];
      TCR_ADDR_CAP_HI: rd_mux = cap_q[15:8];
      TCR_ADDR_CAP_LO: rd_mux = cap_q[7:0];
      TCR_ADDR_MATCH_HI: rd_mux = match_q[15:8];
      TCR_ADDR_MATCH_LO: rd_mux = match_q[7:0];
      TCR_ADDR_MASK_HI: rd_mux = mask_q[15:8];
      TCR_ADDR_MASK_LO: rd_mux = mask_q[7:0];
      default: rd_mux = TCR_BYTE_ZERO;
    endcase
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= TCR_BYTE_ZERO;
    end else begin
      rdata_q <= i_rd ? rd_mux : TCR_BYTE_ZERO;
    end
  end

  assign o_rdata = rdata_q;
  assign o_wrap_output_pin = wrap_pin_q;

  // interrupt: OR of flag-and-enable pairs, follows enable writes at once
  assign o_irq = (flag_a_q && capctl_q.input_a_irq_enable) ||
                 (flag_b_q && bctl_q.input_b_irq_enable) ||
                 (wrap_flag_q && main_q.wrap_irq_enable) ||
                 (match_flag_q && bctl_q.match_irq_enable) ||
                 (null_flag_q && bctl_q.masked_null_irq_enable);

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  irq_pair_a: assert property (
    (flag_b_q && bctl_q.input_b_irq_enable) |-> o_irq)
    else $error("irq low with input b flag and enable set");
  enable_raise_a: assert property (
    (wrap_flag_q && wr_main && i_wdata[TCR_MAIN_WRAP_IE] &&
     i_wdata[TCR_MAIN_WRAP_FLAG]) |=> o_irq)
    else $error("irq did not rise after enable write");
  run_clear_a: assert property (
    !run |=> (cnt_q == TCR_CNT_ZERO))
    else $error("counter not held at zero while stopped");
  reload_err_a: assert property (
    (load_a && flag_a_q) |=> (err_a_q && cnt_q == $past(refill_q)))
    else $error("error flag not set with input a reload");
  capture_b_a: assert property (
    cap_b |=> (cap_q == $past(cnt_q) && flag_b_q))
    else $error("capture register missed counter value");
  block_b_a: assert property (
    err_b_q |=> $stable(cap_q))
    else $error("capture happened with input b error set");
  free_capture_a: assert property (
    (ev_a && !flag_a_q && !refill_en) |=>
      (refill_q == $past(cnt_q)))
    else $error("input a capture into refill register missed");
  free_wrap_a: assert property (
    (wrap_evt && !refill_en && run) |=> (cnt_q == TCR_CNT_TOP))
    else $error("free running counter did not wrap to top");
  wrap_toggle_a: assert property (
    (wrap_evt && main_q.wrap_output_style) |=>
      (wrap_pin_q != $past(wrap_pin_q)))
    else $error("wrap pin did not toggle");
  div16_gap_a: assert property (
    (tick && main_q.divider_select == TCR_DIV_OFF + 2'h3 && !wr_main) |=>
      !tick [*8])
    else $error("divide by sixteen tick came too soon");
  cov_a_restart: cover property (load_a ##[1:50] cap_b);
  cov_b_restart: cover property (load_b && cap_b);
  cov_free_cap: cover property (cap_a ##[1:50] set_err_a);
  cov_irq: cover property (!o_irq ##1 o_irq);

endmodule : tcr_top

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import tcr_pkg::*;
;
  localparam logic [7:0] a_main = TCR_ADDR_MAIN;
  localparam logic [7:0] a_cap = TCR_ADDR_CAPCTL;
  localparam logic [7:0] a_b = TCR_ADDR_BCTL;
  localparam logic [7:0] a_rh = TCR_ADDR_REFILL_HI;
  localparam logic [7:0] a_ch = TCR_ADDR_CAP_HI;
  logic i_clock, i_rst, i_wr, i_rd, lvl_a, lvl_b, pin_a, pin_b;
  logic o_irq, o_wrap;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [15:0] v1, v2;
  int fail_count = 0;
  int total_checks = 0;

  tcr_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_input_a_pin(pin_a), .i_input_b_pin(pin_b), .o_irq(o_irq),
    .o_wrap_output_pin(o_wrap));
  tcr_pin_model pins (.i_clock(i_clock), .i_rst(i_rst), .i_level_a(lvl_a),
    .i_level_b(lvl_b), .o_pin_a(pin_a), .o_pin_b(pin_b));

  // free running clock, 5 ns period
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rc

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] h, l;
    rd(a, h);
    rd(a + 8'h01, l);
    v = {h, l};
  endtask : rd16

  // set pin levels and let the edge settle into the flags
  task automatic lv(input logic a, input logic b);
    @(posedge i_clock);
    lvl_a <= a;
    lvl_b <= b;
    repeat (3) @(posedge i_clock);
  endtask : lv

  task automatic do_reset();
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask : do_reset

  // restart modes: divider first, refill value, source, then run
  task automatic arm(input logic [1:0] src, input logic [15:0] refill);
    do_reset();
    wr(a_main, 8'h60);
    wr(a_rh, refill[15:8]);
    wr(a_rh + 8'h01, refill[7:0]);
    wr(a_cap, {6'h00, src});
    wr(a_main, 8'h70);
  endtask : arm

  task automatic t_reset();
    rc(a_main, 8'h00, "main");
    rc(a_cap, 8'h00, "capctl");
    rc(a_b, 8'h00, "bctl");
    rc(8'he5, 8'h00, "unmapped");
    chk1("irq", 1'b0, o_irq);
  endtask : t_reset

  task automatic t_free();
    wr(a_main, 8'h40);
    lv(0, 0);
    lv(1, 1);
    rc(a_cap, 8'h00, "run off");
    wr(a_main, 8'h50);
    lv(0, 1);
    lv(1, 1);
    rc(a_cap, 8'h08, "a flag");
    rd16(a_rh, v1);
    chk1("free top", 1'b1, v1[15:12] === 4'hf);
    lv(0, 1);
    lv(1, 1);
    rc(a_cap, 8'h48, "a error");
    rd16(a_rh, v2);
    chk("refill kept", v1, v2);
    lv(1, 0);
    lv(1, 1);
    rc(a_b, 8'h2a, "b flag");
    lv(1, 0);
    lv(1, 1);
    rc(a_cap, 8'h68, "b error");
    chk1("irq masked", 1'b0, o_irq);
    wr(a_cap, 8'h78);
    @(posedge i_clock);
    #1 chk1("irq late", 1'b1, o_irq);
    wr(a_cap, 8'h00);
    rc(a_cap, 8'h00, "cleared");
    wr(a_cap, 8'h68);
    rc(a_cap, 8'h00, "no set");
    wr(a_b, 8'h00);
  endtask : t_free

  task automatic t_edges();
    wr(a_cap, 8'h04);
    wr(a_b, 8'h80);
    lv(0, 0);
    rc(a_cap, 8'h04, "a falling");
    rc(a_b, 8'h8a, "b falling");
    lv(1, 1);
    rc(a_cap, 8'h0c, "a rising");
    rc(a_b, 8'haa, "b rising");
  endtask : t_edges

  task automatic t_bmode();
    arm(TCR_SRC_B, 16'h1234);
    rc(a_rh, 8'h12, "refill hi");
    rc(a_rh + 8'h01, 8'h34, "refill lo");
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v1);
    chk("first cap", 16'h0000, v1);
    rc(a_b, 8'h2a, "b flag");
    lv(0, 1);
    lv(1, 1);
    rc(a_cap, 8'h0a, "a only");
    rd16(a_ch, v1);
    chk("cap kept", 16'h0000, v1);
    wr(a_b, 8'h00);
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v1);
    chk1("cap moved", 1'b1, v1 !== 16'h0000);
  endtask : t_bmode

  task automatic t_amode();
    arm(TCR_SRC_A, 16'h0100);
    lv(0, 1);
    lv(1, 1);
    rc(a_cap, 8'h09, "a reload");
    lv(0, 1);
    lv(1, 1);
    rc(a_cap, 8'h49, "a error");
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v1);
    rc(a_b, 8'h2a, "b flag");
    lv(1, 0);
    lv(1, 1);
    rc(a_cap, 8'h69, "b error");
    rd16(a_ch, v2);
    chk("cap blocked", v1, v2);
    wr(a_b, 8'h00);
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v2);
    chk("err blocks", v1, v2);
    wr(a_cap, 8'h01);
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v2);
    chk1("cap resumed", 1'b1, v2 !== v1);
    wr(a_b, 8'h00);
    lv(0, 0);
    lv(1, 1);
    rd16(a_ch, v2);
    chk1("cap first", 1'b1, v2 < 16'h0100);
    wr(a_cap, 8'h01);
    lv(0, 1);
    lv(1, 1);
    repeat (270) @(posedge i_clock);
    rc(a_main, 8'h74, "wrap flag");
    chk1("pin set", 1'b1, o_wrap);
    wr(a_main, 8'h7c);
    @(posedge i_clock);
    #1 chk1("wrap irq", 1'b1, o_irq);
    wr(a_main, 8'h78);
    repeat (2) @(posedge i_clock);
    #1 chk1("pin clear", 1'b0, o_wrap);
    chk1("irq gone", 1'b0, o_irq);
  endtask : t_amode

  task automatic t_soft();
    arm(TCR_SRC_SOFT, 16'h0100);
    lv(1, 0);
    lv(1, 1);
    rd16(a_ch, v1);
    chk1("soft start", 1'b1, v1 !== 16'h0000);
  endtask : t_soft

  // free run: A and B captures 16 cycles apart differ by 16 / ratio
  task automatic t_div(input logic [7:0] sel, input logic [15:0] e,
                       input string n);
    do_reset();
    wr(a_main, sel);
    wr(a_main, sel | 8'h10);
    lv(0, 1);
    repeat (12) @(posedge i_clock);
    lv(0, 0);
    rd16(a_rh, v1);
    rd16(a_ch, v2);
    chk(n, e, v1 - v2);
    lv(1, 1);
  endtask : t_div

  // toggle style: one pin change per four-cycle wrap period
  task automatic t_toggle();
    logic p;
    arm(TCR_SRC_NONE, 16'h0003);
    wr(a_main, 8'h72);
    @(posedge i_clock);
    #1 p = o_wrap;
    repeat (4) @(posedge i_clock);
    #1 chk1("toggle", !p, o_wrap);
    repeat (4) @(posedge i_clock);
    #1 chk1("toggle back", p, o_wrap);
    chk1("match masked", 1'b0, o_irq);
    wr(a_b, 8'h10);
    @(posedge i_clock);
    #1 chk1("match irq", 1'b1, o_irq);
  endtask : t_toggle

  // main sequence
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    lvl_a = 1'b1;
    lvl_b = 1'b1;
    do_reset();
    t_reset();
    t_free();
    t_edges();
    t_bmode();
    t_amode();
    t_soft();
    t_div(8'h80, 16'h0004, "div4");
    t_div(8'hc0, 16'h0001, "div16");
    t_toggle();
    stop_test();
  end

  // watchdog well past the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    stop_test();
  end
endmodule : tb_top

`default_nettype wire

/* tb/tcr_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

// far side timing source: drives both capture inputs from bench levels
module tcr_pin_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_level_a,
  input wire logic i_level_b,
  output logic o_pin_a,
  output logic o_pin_b
);
  // pins idle high and follow each level one clock later
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pin_a <= 1'b1;
      o_pin_b <= 1'b1;
    end else begin
      o_pin_a <= i_level_a;
      o_pin_b <= i_level_b;
    end
  end
endmodule : tcr_pin_model

`default_nettype wire
